// [verilog/tec_pkg.sv]
// package: constants and types for the timer/event counter
package tec_pkg;
  localparam logic [7:0] TEC_ADDR_COUNT   = 8'h0d;
  localparam logic [7:0] TEC_ADDR_CONTROL = 8'h0e;
  localparam logic [7:0] TEC_CTRL_RESET   = 8'h08;
  localparam logic [7:0] TEC_CTRL_WMASK   = 8'hdf;
  localparam int         TEC_BIT_PSC_LO   = 0;
  localparam int         TEC_BIT_EDGE     = 3;
  localparam int         TEC_BIT_ENABLE   = 4;
  localparam int         TEC_BIT_MODE_LO  = 6;
  localparam logic [7:0] TEC_COUNT_MAX    = 8'hff;
  localparam int         TEC_PSC_STAGES   = 8;

  typedef enum logic [1:0] {
    TEC_MODE_UNUSED = 2'h0,
    TEC_MODE_EVENT  = 2'h1,
    TEC_MODE_TIMER  = 2'h2,
    TEC_MODE_PULSE  = 2'h3
  } tec_mode_t;

  typedef enum {TEC_PW_WAIT, TEC_PW_COUNT, TEC_PW_DONE} tec_pw_state_t;

  typedef struct packed {
    logic       wr;
    logic       rd;
    logic [7:0] addr;
    logic [7:0] wdata;
  } tec_bus_t;
endpackage

// [verilog/tec_timer.sv]
// timer/event counter with preload, prescaler, pulse-width mode and buzzer divider
`timescale 1ns/10ps

module tec_timer
  import tec_pkg::*;
#(
  parameter int PSC_STAGES = TEC_PSC_STAGES
)
(
  input  wire logic       i_clk,
  input  wire logic       i_arst_n,
  input  wire logic       i_wr,
  input  wire logic       i_rd,
  input  wire logic [7:0] i_addr,
  input  wire logic [7:0] i_wdata,
  input  wire logic       i_timer_input_pin,
  input  wire logic       i_overflow_irq_enable,
  input  wire logic       i_flag_clear,
  input  wire logic       i_buzzer_option,
  input  wire logic       i_pin_true_is_output,
  input  wire logic       i_pin_inverted_is_output,
  input  wire logic       i_port_data0,
  output logic [7:0]      o_rdata,
  output logic            o_counter_overflow_flag,
  output logic            o_irq,
  output logic            o_wakeup,
  output logic            o_divider_output,
  output logic            o_buzzer_pin_true,
  output logic            o_buzzer_pin_inverted,
  output logic            o_buzzer_drive_true,
  output logic            o_buzzer_drive_inverted
);

  tec_bus_t      bus;
  logic [7:0]    count_reg;
  logic [7:0]    preload_reg;
  logic [7:0]    control_reg;
  logic [7:0]    fields_reg;
  logic          enable_reg;
  logic [PSC_STAGES-1:0] psc_reg;
  logic          pin_reg;
  tec_pw_state_t pw_reg;
  logic          div_reg;
  tec_mode_t     mode;
  logic          enable;
  logic          edge_sel;
  logic [2:0]    psc_sel;
  logic          psc_tick;
  logic          rise;
  logic          fall;
  logic          count_tick;
  logic          overflow;
  logic          pw_stop;
  logic          pw_start;
  logic          wr_count;
  logic          wr_control;
  logic          rd_count;
  logic [7:0]    rdata_next;
  logic [7:0]    count_next;

  assign bus        = '{wr: i_wr, rd: i_rd, addr: i_addr, wdata: i_wdata};
  assign mode       = tec_mode_t'(control_reg[TEC_BIT_MODE_LO +: 2]);
  assign enable     = control_reg[TEC_BIT_ENABLE];
  assign edge_sel   = control_reg[TEC_BIT_EDGE];
  assign psc_sel    = control_reg[TEC_BIT_PSC_LO +: 3];
  assign wr_count   = bus.wr && (bus.addr == TEC_ADDR_COUNT);
  assign wr_control = bus.wr && (bus.addr == TEC_ADDR_CONTROL);
  assign rd_count   = bus.rd && (bus.addr == TEC_ADDR_COUNT);
  assign rise       = i_timer_input_pin && !pin_reg;
  assign fall       = !i_timer_input_pin && pin_reg;

  // ripple prescaler, one toggle stage per bit; stage k runs at sys/2^(k+1)
  logic [PSC_STAGES-1:0] psc_carry;
  logic [PSC_STAGES-1:0] psc_fall;

  for (genvar g = 0; g < PSC_STAGES; g++) begin : g_psc
    logic stage_reg;

    if (g == 0) begin : g_first
      assign psc_carry[g] = 1'b1;
    end else begin : g_next
      assign psc_carry[g] = psc_carry[g-1] && psc_reg[g-1];
    end

    always_ff @(posedge i_clk or negedge i_arst_n) begin
      if (!i_arst_n) begin
        stage_reg <= 1'b0;
      end else if (psc_carry[g]) begin
        stage_reg <= !stage_reg;
      end
    end

    assign psc_reg[g]  = stage_reg;
    // a stage falls when it is high and its carry arrives
    assign psc_fall[g] = psc_carry[g] && stage_reg;
  end : g_psc

  assign psc_tick = psc_fall[psc_sel];

  always_ff @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      // low matches the idle source level, so no false edge after reset
      pin_reg <= 1'b0;
    end else begin
      pin_reg <= i_timer_input_pin;
    end
  end

  // the stop edge is the reverse of the start edge
  always_comb begin
    pw_start = 1'b0;
    pw_stop  = 1'b0;
    if (edge_sel) begin
      pw_start = rise;
      pw_stop  = fall;
    end else begin
      pw_start = fall;
      pw_stop  = rise;
    end
    if (pw_reg != TEC_PW_COUNT) begin
      pw_stop = 1'b0;
    end
  end

  always_comb begin
    count_tick = 1'b0;
    if (enable && !rd_count) begin
      unique case (mode)
        TEC_MODE_EVENT: begin
          if (edge_sel) begin
            count_tick = fall;
          end else begin
            count_tick = rise;
          end
        end
        TEC_MODE_TIMER: begin
          count_tick = psc_tick;
        end
        TEC_MODE_PULSE: begin
          // the stop-edge cycle is not counted
          count_tick = psc_tick && (pw_reg == TEC_PW_COUNT) && !pw_stop;
        end
        TEC_MODE_UNUSED: begin
          count_tick = 1'b0;
        end
      endcase
    end
  end

  assign overflow = count_tick && (count_reg == TEC_COUNT_MAX);

  // pulse-width sequencer: waits for a true edge, so a level at enable is ignored
  always_ff @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      pw_reg <= TEC_PW_WAIT;
    end else if (mode != TEC_MODE_PULSE || !enable) begin
      pw_reg <= TEC_PW_WAIT;
    end else begin
      unique case (pw_reg)
        TEC_PW_WAIT: begin
          if (pw_start) begin
            pw_reg <= TEC_PW_COUNT;
          end
        end
        TEC_PW_COUNT: begin
          if (pw_stop) begin
            pw_reg <= TEC_PW_DONE;
          end
        end
        TEC_PW_DONE: begin
          // left on the next cycle: the stop edge also clears enable, which drops back to wait
          pw_reg <= TEC_PW_DONE;
        end
      endcase
    end
  end

  // mode, edge and prescale fields change only by software
  always_ff @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      fields_reg <= TEC_CTRL_RESET;
    end else if (wr_control) begin
      fields_reg <= bus.wdata & TEC_CTRL_WMASK;
    end
  end

  // enable is also dropped by hardware at the end of a pulse measurement
  always_ff @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      enable_reg <= TEC_CTRL_RESET[TEC_BIT_ENABLE];
    end else if (wr_control) begin
      enable_reg <= bus.wdata[TEC_BIT_ENABLE];
    end else if (pw_stop && mode == TEC_MODE_PULSE) begin
      enable_reg <= 1'b0;
    end
  end

  always_comb begin
    control_reg                 = fields_reg;
    control_reg[TEC_BIT_ENABLE] = enable_reg;
  end

  always_ff @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      preload_reg <= 8'h00;
    end else if (wr_count) begin
      preload_reg <= bus.wdata;
    end
  end

  // a stopped write wins; while running a write only reaches the preload
  always_comb begin
    count_next = count_reg;
    if (wr_count && !enable) begin
      count_next = bus.wdata;
    end else if (overflow) begin
      count_next = preload_reg;
    end else if (count_tick) begin
      count_next = count_reg + 8'h01;
    end
  end

  always_ff @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      count_reg <= 8'h00;
    end else begin
      count_reg <= count_next;
    end
  end

  // set wins over a simultaneous clear
  always_ff @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      o_counter_overflow_flag <= 1'b0;
    end else if (overflow) begin
      o_counter_overflow_flag <= 1'b1;
    end else if (i_flag_clear) begin
      o_counter_overflow_flag <= 1'b0;
    end
  end

  // a fresh overflow reaches the request without waiting for the flag
  always_ff @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      o_irq <= 1'b0;
    end else begin
      o_irq <= i_overflow_irq_enable && (o_counter_overflow_flag || overflow);
    end
  end

  always_ff @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      o_wakeup <= 1'b0;
    end else begin
      o_wakeup <= overflow;
    end
  end

  always_ff @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      div_reg <= 1'b0;
    end else if (overflow) begin
      div_reg <= !div_reg;
    end
  end

  always_ff @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      o_divider_output <= 1'b0;
    end else begin
      o_divider_output <= div_reg;
    end
  end

  // buzzer pad levels: port data bit 0 gates both pins
  always_ff @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      o_buzzer_pin_true     <= 1'b0;
      o_buzzer_pin_inverted <= 1'b0;
    end else begin
      o_buzzer_pin_true     <= i_port_data0 && div_reg;
      o_buzzer_pin_inverted <= i_port_data0 && !div_reg;
    end
  end

  // low-active enables; an input-mode pin keeps its ordinary function
  always_ff @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      o_buzzer_drive_true     <= 1'b1;
      o_buzzer_drive_inverted <= 1'b1;
    end else begin
      o_buzzer_drive_true     <= !(i_buzzer_option && i_pin_true_is_output);
      o_buzzer_drive_inverted <= !(i_buzzer_option && i_pin_inverted_is_output);
    end
  end

  always_comb begin
    rdata_next = o_rdata;
    if (bus.rd) begin
      unique case (bus.addr)
        TEC_ADDR_COUNT: begin
          rdata_next = count_reg;
        end
        TEC_ADDR_CONTROL: begin
          rdata_next = control_reg & TEC_CTRL_WMASK;
        end
        default: begin
          rdata_next = 8'h00;
        end
      endcase
    end
  end

  always_ff @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      o_rdata <= 8'h00;
    end else begin
      o_rdata <= rdata_next;
    end
  end

endmodule // tec_timer

// [verif/tec_timer_asserts.sv]
// checker: port-level properties of the timer/event counter
`timescale 1ns/10ps
module tec_timer_asserts
  import tec_pkg::*;
(
  input wire logic       i_clk,
  input wire logic       i_arst_n,
  input wire logic       i_wr,
  input wire logic       i_rd,
  input wire logic [7:0] i_addr,
  input wire logic [7:0] i_wdata,
  input wire logic       i_overflow_irq_enable,
  input wire logic       i_flag_clear,
  input wire logic       i_port_data0,
  input wire logic       i_buzzer_option,
  input wire logic       i_pin_true_is_output,
  input wire logic       o_buzzer_drive_true,
  input wire logic [7:0] o_rdata,
  input wire logic       o_counter_overflow_flag,
  input wire logic       o_irq,
  input wire logic       o_wakeup,
  input wire logic       o_divider_output,
  input wire logic       o_buzzer_pin_true,
  input wire logic       o_buzzer_pin_inverted
);
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_arst_n);
  sequence s_wr_ctrl; i_wr && i_addr == TEC_ADDR_CONTROL; endsequence
  sequence s_rd_ctrl; i_rd && i_addr == TEC_ADDR_CONTROL; endsequence
  property p_unused; s_rd_ctrl |=> !o_rdata[5]; endproperty
  a_unused: assert property (p_unused) else $error("control bit 5 read back set");
  property p_mode;
    s_wr_ctrl ##2 s_rd_ctrl |=> o_rdata[7:6] == $past(i_wdata[7:6], 3);
  endproperty
  a_mode: assert property (p_mode) else $error("mode bits not kept");
  property p_flag; o_counter_overflow_flag && !i_flag_clear |=> o_counter_overflow_flag;
  endproperty
  a_flag: assert property (p_flag) else $error("overflow flag lost");
  property p_wake; $rose(o_counter_overflow_flag) |-> o_wakeup; endproperty
  a_wake: assert property (p_wake) else $error("no wake pulse on overflow");
  property p_div; o_wakeup |=> $changed(o_divider_output); endproperty
  a_div: assert property (p_div) else $error("divider did not toggle");
  property p_irq_off; !i_overflow_irq_enable |=> !o_irq; endproperty
  a_irq_off: assert property (p_irq_off) else $error("irq while disabled");
  property p_irq_on; o_counter_overflow_flag && i_overflow_irq_enable |=> o_irq; endproperty
  a_irq_on: assert property (p_irq_on) else $error("irq missing");
  property p_buz_low;
    !i_port_data0 |=> !o_buzzer_pin_true && !o_buzzer_pin_inverted;
  endproperty
  a_buz_low: assert property (p_buz_low) else $error("buzzer pad not forced low");
  property p_buz_pair;
    i_port_data0 |=> o_buzzer_pin_true != o_buzzer_pin_inverted;
  endproperty
  a_buz_pair: assert property (p_buz_pair) else $error("buzzer pads not complementary");
  property p_drive;
    i_buzzer_option && i_pin_true_is_output |=> !o_buzzer_drive_true;
  endproperty
  a_drive: assert property (p_drive) else $error("buzzer pad not driven");
endmodule // tec_timer_asserts

bind tec_timer tec_timer_asserts i_chk (.*);

// [verif/tec_src.sv]
// partner model: external pulse source on the timer input pin
`timescale 1ns/10ps
module tec_src (
  input  wire logic       i_clk,
  input  wire logic       i_go,
  input  wire logic       i_idle,
  input  wire logic [7:0] i_len,
  output logic            o_pin
);
  logic [7:0] left_reg = 8'h00;
  always_ff @(posedge i_clk) begin
    if (i_go) left_reg <= i_len;
    else if (left_reg != 8'h00) left_reg <= left_reg - 8'h01;
  end
  // pin leaves its idle level for i_len clocks per request
  assign o_pin = (left_reg != 8'h00) ? !i_idle : i_idle;
endmodule // tec_src

// [verif/tec_timer_tb.sv]
// self-checking bench for the timer/event counter
`timescale 1ns/10ps
module tec_timer_tb;
  import tec_pkg::*;
  logic       clk = 1'b0, arst_n = 1'b0, wr = 1'b0, rd = 1'b0, go = 1'b0;
  logic       irq_en = 1'b1, fclr = 1'b0, data0 = 1'b0, pin, flag, irq, wake, div;
  logic       idle = 1'b0;
  logic [7:0] addr = 8'h00, wdata = 8'h00, len = 8'h00, rdata;
  int         bad_count = 0, cmp_count = 0, cyc = 0;
  time        t0;
  tec_src i_src (.i_clk(clk), .i_go(go), .i_idle(idle), .i_len(len), .o_pin(pin));
  tec_timer i_dut (.i_clk(clk), .i_arst_n(arst_n), .i_wr(wr), .i_rd(rd), .i_addr(addr),
    .i_wdata(wdata), .i_timer_input_pin(pin), .i_overflow_irq_enable(irq_en),
    .i_flag_clear(fclr), .i_buzzer_option(1'b1), .i_pin_true_is_output(1'b1),
    .i_pin_inverted_is_output(1'b1), .i_port_data0(data0), .o_rdata(rdata),
    .o_counter_overflow_flag(flag), .o_irq(irq), .o_wakeup(wake), .o_divider_output(div),
    .o_buzzer_pin_true(), .o_buzzer_pin_inverted(), .o_buzzer_drive_true(),
    .o_buzzer_drive_inverted());
  always #50 clk = ~clk;
  task automatic complete_run;
    $display("compares %0d mismatches %0d", cmp_count, bad_count);
    if (bad_count == 0 && cmp_count > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  always @(posedge clk) begin
    cyc++;
    // far above the roughly seven thousand cycles the tests need
    if (cyc == 40000) begin
      bad_count++;
      complete_run;
    end
  end
  task automatic step; @(posedge clk); #10; endtask
  task automatic chk(input string nm, input logic [15:0] seen, input logic [15:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      bad_count++;
      $display("Error %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic wreg(input logic [7:0] a, input logic [7:0] d);
    wr = 1'b1; addr = a; wdata = d; step; wr = 1'b0; step;
  endtask
  task automatic rreg(input logic [7:0] a, input logic [7:0] exp, input string nm);
    rd = 1'b1; addr = a; step; chk(nm, {8'h00, rdata}, {8'h00, exp}); rd = 1'b0; step;
  endtask
  task automatic pulse(input logic [7:0] n); go = 1'b1; len = n; step; go = 1'b0; endtask
  initial begin
    repeat (12) @(posedge clk);
    #10 arst_n = 1'b1;
    rreg(TEC_ADDR_CONTROL, 8'h08, "control reset");
    rreg(8'h20, 8'h00, "unmapped");
    wreg(TEC_ADDR_CONTROL, 8'hff);
    rreg(TEC_ADDR_CONTROL, 8'hdf, "control bits");
    wreg(TEC_ADDR_CONTROL, 8'h08);
    wreg(TEC_ADDR_COUNT, 8'h42);
    rreg(TEC_ADDR_COUNT, 8'h42, "stopped load");
    for (int e = 0; e < 2; e++) begin
      wreg(TEC_ADDR_CONTROL, 8'h08);
      wreg(TEC_ADDR_COUNT, 8'h00);
      wreg(TEC_ADDR_CONTROL, {2'h1, 2'h1, 1'(e), 3'h0});
      pulse(8'd20);
      repeat (6) step;
      rreg(TEC_ADDR_COUNT, 8'(1 - e), "edge mid pulse");
      repeat (20) step;
      rreg(TEC_ADDR_COUNT, 8'h01, "edge count");
    end
    wreg(TEC_ADDR_CONTROL, 8'h08);
    wreg(TEC_ADDR_COUNT, 8'hfe);
    data0 = 1'b1;
    for (int p = 0; p < 8; p++) begin
      wreg(TEC_ADDR_CONTROL, {2'h2, 2'h1, 1'h0, 3'(p)});
      @(posedge div); @(posedge div); t0 = $time;
      @(posedge div);
      chk("pfd period", 16'(($time - t0) / 100), 16'(2 * (256 - 254)) << (p + 1));
      #10;
    end
    chk("flag", {15'h0, flag}, 16'h1);
    chk("irq", {15'h0, irq}, 16'h1);
    wreg(TEC_ADDR_CONTROL, 8'h08);
    irq_en = 1'b0; fclr = 1'b1; step; fclr = 1'b0; step;
    chk("flag clear", {15'h0, flag}, 16'h0);
    wreg(TEC_ADDR_COUNT, 8'h00);
    pulse(8'd60);
    // enabled while the pin already sits high: must not measure
    wreg(TEC_ADDR_CONTROL, 8'hd8);
    repeat (70) step;
    rreg(TEC_ADDR_COUNT, 8'h00, "level start");
    rreg(TEC_ADDR_CONTROL, 8'hd8, "still armed");
    for (int k = 0; k < 2; k++) begin
      pulse(k == 0 ? 8'd40 : 8'd100);
      repeat (110) step;
      rreg(TEC_ADDR_CONTROL, 8'hc8, "enable cleared");
      rd = 1'b1; addr = TEC_ADDR_COUNT; step;
      chk("pulse width", 16'(rdata >= 8'd19 && rdata <= 8'd20), 16'h1);
      rd = 1'b0; step;
    end
    // low-level measurement, re-armed by software after the held result
    idle = 1'b1; step; step;
    wreg(TEC_ADDR_COUNT, 8'h00);
    wreg(TEC_ADDR_CONTROL, 8'hd0);
    pulse(8'd30);
    repeat (40) step;
    rreg(TEC_ADDR_CONTROL, 8'hc0, "low enable cleared");
    rd = 1'b1; addr = TEC_ADDR_COUNT; step;
    chk("low width", 16'(rdata >= 8'd14 && rdata <= 8'd15), 16'h1);
    rd = 1'b0; step;
    complete_run;
  end
endmodule // tec_timer_tb
